// ==== pkg/pwr_seq_pkg.sv ====
package pwr_seq_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
  localparam int unsigned DISCHARGE_MS = 10;
  localparam int unsigned POR_HOLD_MS = 110;
  localparam int unsigned BUS_WAIT_MS = 150;
  localparam int unsigned RADIO_HOLD_MS = 100;
  localparam int unsigned DISCHARGE_CYC = DISCHARGE_MS * CLK_PER_MS;
  localparam int unsigned POR_HOLD_CYC = POR_HOLD_MS * CLK_PER_MS;
  localparam int unsigned BUS_WAIT_CYC = BUS_WAIT_MS * CLK_PER_MS;
  localparam int unsigned RADIO_HOLD_CYC = RADIO_HOLD_MS * CLK_PER_MS;

  localparam int unsigned CNT_W = 23;
  localparam logic [CNT_W-1:0] CNT_RST = 23'h00_0000;

endpackage

// ==== pkg/pwr_seq_if.sv ====
`timescale 1ns/100ps
interface pwr_seq_if;
  logic wireless_power_enable;
  logic radio_link_power_enable;
  logic supplies_up;

  modport dev (
    input wireless_power_enable,
    input radio_link_power_enable,
    output supplies_up
  );

  modport host (
    output wireless_power_enable,
    output radio_link_power_enable,
    input supplies_up
  );
endinterface

// ==== hw/pwr_seq_host.sv ====
`timescale 1ns/100ps
module pwr_seq_host
  import pwr_seq_pkg::*;
#(
  parameter int unsigned DISCHARGE_CYCLES = DISCHARGE_CYC,
  parameter int unsigned BUS_WAIT_CYCLES = BUS_WAIT_CYC,
  parameter int unsigned RADIO_HOLD_CYCLES = RADIO_HOLD_CYC
)
(
  input wire logic clk,
  input wire logic resetn,
  pwr_seq_if.host link,
  input wire logic wireless_want,
  input wire logic radio_want,
  output logic bus_access_ok,
  output logic busy
);

  typedef enum logic [2:0] {OFF, DISCHARGE, RADIO_UP, BOTH_UP, RADIO_DROP} host_state_e;

  host_state_e state_r, state_nxt;
  logic wl_r, wl_nxt, bt_r, bt_nxt;
  logic ok_r, ok_nxt, busy_r, busy_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, bus_cnt_r, bus_cnt_nxt;

  // ----------------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    wl_nxt = wl_r;
    bt_nxt = bt_r;
    cnt_nxt = (cnt_r == CNT_RST) ? cnt_r : cnt_r - 23'h00_0001;
    unique case (state_r)
      OFF:
      begin
        if (wireless_want || radio_want)
        begin
          bt_nxt = 1'b1;
          state_nxt = RADIO_UP;
        end
      end
      RADIO_UP:
      begin
        if (wireless_want)
        begin
          wl_nxt = 1'b1;
          cnt_nxt = CNT_W'(RADIO_HOLD_CYCLES);
          state_nxt = BOTH_UP;
        end
        else if (!radio_want)
        begin
          bt_nxt = 1'b0;
          cnt_nxt = CNT_W'(DISCHARGE_CYCLES);
          state_nxt = DISCHARGE;
        end
      end
      BOTH_UP:
      begin
        if (!radio_want && cnt_r == CNT_RST)
        begin
          bt_nxt = 1'b0;
          state_nxt = RADIO_DROP;
        end
        else if (!wireless_want && !radio_want && cnt_r == CNT_RST)
        begin
          state_nxt = RADIO_DROP;
        end
        else if (!wireless_want)
        begin
          wl_nxt = 1'b0;
          state_nxt = RADIO_UP;
        end
      end
      RADIO_DROP:
      begin
        if (!wireless_want)
        begin
          wl_nxt = 1'b0;
          bt_nxt = 1'b0;
          cnt_nxt = CNT_W'(DISCHARGE_CYCLES);
          state_nxt = DISCHARGE;
        end
        else if (radio_want)
        begin
          bt_nxt = 1'b1;
          state_nxt = BOTH_UP;
        end
      end
      DISCHARGE:
      begin
        if (cnt_r == CNT_RST)
        begin
          state_nxt = OFF;
        end
      end
    endcase
    bus_cnt_nxt = bus_cnt_r;
    ok_nxt = 1'b0;
    if (!link.supplies_up || !wl_r)
    begin
      bus_cnt_nxt = CNT_W'(BUS_WAIT_CYCLES);
    end
    else if (bus_cnt_r != CNT_RST)
    begin
      bus_cnt_nxt = bus_cnt_r - 23'h00_0001;
    end
    else
    begin
      ok_nxt = 1'b1;
    end
    busy_nxt = (state_nxt == DISCHARGE);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= OFF;
      wl_r <= 1'b0;
      bt_r <= 1'b0;
      cnt_r <= CNT_RST;
      bus_cnt_r <= CNT_RST;
      ok_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      wl_r <= wl_nxt;
      bt_r <= bt_nxt;
      cnt_r <= cnt_nxt;
      bus_cnt_r <= bus_cnt_nxt;
      ok_r <= ok_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign link.wireless_power_enable = wl_r;
  assign link.radio_link_power_enable = bt_r;
  assign bus_access_ok = ok_r;
  assign busy = busy_r;

endmodule

// ==== hw/pwr_seq_dev.sv ====
`timescale 1ns/100ps
// Summary of operation
// - Regulators on when either enable high.
// - Wireless reset follows wireless enable low.
// - Both enables low disables all regulators.
// - Radio reset while its enable low.
// - Host waits 10 ms between toggles; here only after both enables drop, a single enable can re-rise next cycle.
// - Power-on reset held at most 110 ms.
// - Host waits 150 ms before bus access.
// - Radio enable rises no later than wireless.
// - Radio enable drops 100 ms after wireless.
// - DDR data both edges, command single edge.
// - Serial port samples on rising edge.
// - Chip select held through whole transaction.
module pwr_seq_dev
  import pwr_seq_pkg::*;
#(
  parameter int unsigned POR_HOLD_CYCLES = POR_HOLD_CYC
)
(
  input wire logic clk,
  input wire logic resetn,
  pwr_seq_if.dev link,
  input wire logic supply_good,
  output logic regulator_enable,
  output logic wireless_reset_n,
  output logic radio_reset_n,
  output logic por_active,
  output logic ddr_data_both_edges,
  output logic serial_rising_sample
);

  typedef enum logic [1:0] {POWER_OFF, POR_HOLD, RUN} dev_state_e;

  dev_state_e state_r, state_nxt;
  logic [1:0] wl_sync_r, wl_sync_nxt, bt_sync_r, bt_sync_nxt;
  logic reg_r, reg_nxt, wl_rst_n_r, wl_rst_n_nxt, bt_rst_n_r, bt_rst_n_nxt;
  logic por_r, por_nxt, up_r, up_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  always_comb
  begin
    wl_sync_nxt = {wl_sync_r[0], link.wireless_power_enable};
    bt_sync_nxt = {bt_sync_r[0], link.radio_link_power_enable};
  end

  // ----------------------------------------------------------------------
  // Regulator, power-on reset and section resets
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    reg_nxt = wl_sync_r[1] | bt_sync_r[1];
    unique case (state_r)
      POWER_OFF:
      begin
        if (reg_r && supply_good)
        begin
          cnt_nxt = CNT_W'(POR_HOLD_CYCLES);
          state_nxt = POR_HOLD;
        end
      end
      POR_HOLD:
      begin
        if (!reg_r || !supply_good)
        begin
          state_nxt = POWER_OFF;
        end
        else if (cnt_r <= 23'h00_0001)
        begin
          state_nxt = RUN;
        end
        else
        begin
          cnt_nxt = cnt_r - 23'h00_0001;
        end
      end
      RUN:
      begin
        if (!reg_r || !supply_good)
        begin
          state_nxt = POWER_OFF;
        end
      end
    endcase
    por_nxt = (state_nxt != RUN);
    up_nxt = (state_nxt == RUN);
    wl_rst_n_nxt = (state_nxt == RUN) && wl_sync_r[1];
    bt_rst_n_nxt = (state_nxt == RUN) && bt_sync_r[1];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wl_sync_r <= 2'h0;
      bt_sync_r <= 2'h0;
      state_r <= POWER_OFF;
      cnt_r <= CNT_RST;
      reg_r <= 1'b0;
      por_r <= 1'b1;
      up_r <= 1'b0;
      wl_rst_n_r <= 1'b0;
      bt_rst_n_r <= 1'b0;
    end
    else
    begin
      wl_sync_r <= wl_sync_nxt;
      bt_sync_r <= bt_sync_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      reg_r <= reg_nxt;
      por_r <= por_nxt;
      up_r <= up_nxt;
      wl_rst_n_r <= wl_rst_n_nxt;
      bt_rst_n_r <= bt_rst_n_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Host port sampling conventions
  // ----------------------------------------------------------------------
  logic ddr_r, spi_r;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ddr_r <= 1'b0;
      spi_r <= 1'b0;
    end
    else
    begin
      ddr_r <= 1'b1;
      spi_r <= 1'b1;
    end
  end

  assign regulator_enable = reg_r;
  assign wireless_reset_n = wl_rst_n_r;
  assign radio_reset_n = bt_rst_n_r;
  assign por_active = por_r;
  assign link.supplies_up = up_r;
  assign ddr_data_both_edges = ddr_r;
  assign serial_rising_sample = spi_r;

endmodule

// ==== testbench/pwr_seq_chk.sv ====
`timescale 1ns/100ps
module pwr_seq_chk #(
  parameter int POR_HOLD_CYCLES = 20,
  parameter int BUS_WAIT_CYCLES = 30,
  parameter int RADIO_HOLD_CYCLES = 10
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic wireless_power_enable,
  input wire logic radio_link_power_enable,
  input wire logic supplies_up,
  input wire logic regulator_enable,
  input wire logic wireless_reset_n,
  input wire logic radio_reset_n,
  input wire logic por_active,
  input wire logic bus_access_ok
);
  wire wl = wireless_power_enable;
  wire rl = radio_link_power_enable;
  logic [15:0] hold_cnt_r;
  logic [15:0] up_cnt_r;
  logic [15:0] por_cnt_r;
  // ----------------------------------------------------------------------
  // Cycle counters.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hold_cnt_r <= 16'h0000;
      up_cnt_r <= 16'h0000;
      por_cnt_r <= 16'h0000;
    end
    else
    begin
      hold_cnt_r <= wl ? hold_cnt_r + 16'h0001 : 16'h0000;
      up_cnt_r <= supplies_up ? up_cnt_r + 16'h0001 : 16'h0000;
      por_cnt_r <= (por_active && regulator_enable) ? por_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  radio_first_a: assert property ($rose(wl) |-> rl)
    else $error("Radio enable rose after wireless enable.");
  radio_hold_a: assert property ($fell(rl) && wl |-> hold_cnt_r >= RADIO_HOLD_CYCLES - 1)
    else $error("Radio enable dropped too early.");
  reg_on_a: assert property ((wl || rl) [*5] |-> regulator_enable)
    else $error("Regulators off with an enable high.");
  reg_off_a: assert property (!(wl || rl) [*5] |-> !regulator_enable)
    else $error("Regulators on with both enables low.");
  wl_reset_a: assert property (!wl [*5] |-> !wireless_reset_n)
    else $error("Wireless section out of reset.");
  rl_reset_a: assert property (!rl [*5] |-> !radio_reset_n)
    else $error("Radio section out of reset.");
  por_bound_a: assert property (por_cnt_r <= POR_HOLD_CYCLES + 4)
    else $error("Power-on reset held too long.");
  bus_wait_a: assert property ($rose(bus_access_ok) |-> up_cnt_r >= BUS_WAIT_CYCLES - 1)
    else $error("Bus access allowed too early.");
  cover property ($rose(bus_access_ok));
  cover property ($fell(rl) && wl);
  cover property ($rose(wl) && rl);
endmodule

// ==== testbench/radio_power_enable_sequencer_tb.sv ====
`timescale 1ns/100ps
module radio_power_enable_sequencer_tb;
  logic clk;
  logic resetn;
  logic wireless_want;
  logic radio_want;
  logic bus_access_ok;
  logic busy;
  logic regulator_enable;
  logic wireless_reset_n;
  logic radio_reset_n;
  logic por_active;
  logic ddr_data_both_edges;
  logic serial_rising_sample;
  int errors;
  int num_checks;
  int cycles;
  pwr_seq_if link ();
  pwr_seq_host #(.DISCHARGE_CYCLES(5), .BUS_WAIT_CYCLES(30), .RADIO_HOLD_CYCLES(10))
    u_pwr_seq_host (.clk(clk), .resetn(resetn), .link(link), .wireless_want(wireless_want),
    .radio_want(radio_want), .bus_access_ok(bus_access_ok), .busy(busy));
  pwr_seq_dev #(.POR_HOLD_CYCLES(20)) u_pwr_seq_dev (.clk(clk), .resetn(resetn), .link(link),
    .supply_good(regulator_enable), .regulator_enable(regulator_enable),
    .wireless_reset_n(wireless_reset_n), .radio_reset_n(radio_reset_n),
    .por_active(por_active), .ddr_data_both_edges(ddr_data_both_edges),
    .serial_rising_sample(serial_rising_sample));
  pwr_seq_chk u_pwr_seq_chk (.clk(clk), .resetn(resetn),
    .wireless_power_enable(link.wireless_power_enable),
    .radio_link_power_enable(link.radio_link_power_enable), .supplies_up(link.supplies_up),
    .regulator_enable(regulator_enable), .wireless_reset_n(wireless_reset_n),
    .radio_reset_n(radio_reset_n), .por_active(por_active), .bus_access_ok(bus_access_ok));
  // ----------------------------------------------------------------------
  // Clock, timeout and shared tasks.
  // ----------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      errors++;
      wrap_up();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic want(input logic w, input logic r, input int n);
    wireless_want = w;
    radio_want = r;
    step(n);
  endtask
  task automatic chk(input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------------
  initial
  begin
    resetn = 1'b0;
    wireless_want = 1'b0;
    radio_want = 1'b0;
    errors = 0;
    num_checks = 0;
    cycles = 0;
    step(16);
    resetn = 1'b1;
    step(2);
    chk(por_active, 1'b1);
    chk(regulator_enable, 1'b0);
    chk(ddr_data_both_edges, 1'b1);
    chk(serial_rising_sample, 1'b1);
    want(1'b0, 1'b1, 40);
    chk(regulator_enable, 1'b1);
    chk(por_active, 1'b0);
    chk(radio_reset_n, 1'b1);
    chk(wireless_reset_n, 1'b0);
    want(1'b1, 1'b1, 45);
    chk(wireless_reset_n, 1'b1);
    chk(bus_access_ok, 1'b1);
    want(1'b1, 1'b0, 8);
    chk(radio_reset_n, 1'b0);
    chk(regulator_enable, 1'b1);
    want(1'b0, 1'b0, 3);
    chk(busy, 1'b1);
    want(1'b1, 1'b1, 30);
    chk(regulator_enable, 1'b1);
    want(1'b0, 1'b0, 20);
    chk(regulator_enable, 1'b0);
    want(1'b1, 1'b0, 45);
    chk(wireless_reset_n, 1'b1);
    chk(regulator_enable, 1'b1);
    wrap_up();
  end
endmodule
